// >>> adc_host_model.sv
`timescale 1ns/1ns
module adc_host_model
  import adc_serial_pkg::*;
(
  output logic serial_clk,
  output logic chip_select_n,
  output logic command_in,
  output logic comparator_high,
  input wire logic result_out,
  input wire logic result_out_oe_n,
  input wire logic [11:0] dac_trial,
  input wire logic [11:0] analog_code
);
  logic line;
  // The data line has a pull-up, so a released output reads as one.
  assign line = result_out_oe_n ? 1'b1 : result_out;
  assign comparator_high = analog_code >= dac_trial;
  initial begin
    serial_clk = 1'b0;
    chip_select_n = 1'b1;
    command_in = 1'b1;
  end
  // Mode zero host; four leading zeros give the device time to arm.
  task automatic frame(input logic [23:0] tx, output logic [23:0] rx);
    #3;
    chip_select_n = 1'b0;
    command_in = 1'b0;
    repeat (4) begin
      #8 serial_clk = 1'b1;
      #7 serial_clk = 1'b0;
    end
    for (int i = 23; i >= 0; i--) begin
      command_in = tx[i];
      #8 serial_clk = 1'b1;
      rx[i] = line;
      #7 serial_clk = 1'b0;
    end
    #8 chip_select_n = 1'b1;
    command_in = 1'b1;
  endtask
endmodule // adc_host_model

// >>> adc_serial_asserts.sv
`timescale 1ns/1ns
module adc_serial_asserts
  import adc_serial_pkg::*;
(
  input wire logic reset_n,
  input wire logic serial_clk,
  input wire logic chip_select_n,
  input wire logic result_out,
  input wire logic conversion_strobe_out,
  input wire logic [11:0] dac_trial,
  input wire mux_type mux_route,
  input wire logic track_enable,
  input wire logic hold_capacitor_to_return,
  input wire control_type active_control
);
  // A high chip select clears the link front end, though not the result word, so it disables too.
  default clocking cb @(negedge serial_clk); endclocking
  default disable iff (chip_select_n || !reset_n);

  sequence track_run;
    track_enable[*3] ##1 !track_enable;
  endsequence

  sequence hold_run;
    hold_capacitor_to_return[*8] ##1 hold_capacitor_to_return[*4]
      ##1 !hold_capacitor_to_return;
  endsequence

  track_span_a: assert property (
    $rose(track_enable) |-> track_run) else $error("track span wrong");
  hold_follow_a: assert property (
    $fell(track_enable) |-> $rose(hold_capacitor_to_return))
    else $error("hold not after track");
  hold_span_a: assert property (
    $rose(hold_capacitor_to_return) |-> hold_run)
    else $error("hold span wrong");
  strobe_width_a: assert property (
    $rose(conversion_strobe_out) |=> !conversion_strobe_out)
    else $error("strobe too long");
  strobe_mode_a: assert property (
    $rose(hold_capacitor_to_return) |-> conversion_strobe_out ==
    (active_control.power_clock_mode_field == MODE_EXTERNAL))
    else $error("strobe vs mode wrong");
  strobe_lead_a: assert property (
    $rose(conversion_strobe_out) |-> !result_out && dac_trial == MSB_TRIAL)
    else $error("lead bit wrong");
  mux_select_a: assert property (
    $rose(hold_capacitor_to_return) |-> mux_route.pos_channel ==
    {active_control.channel_select_field[1:0],
    active_control.channel_select_field[2]} &&
    mux_route.ret_ground == active_control.input_config_bit)
    else $error("positive route wrong");
  mux_pair_a: assert property (
    $rose(hold_capacitor_to_return) && !active_control.input_config_bit
    |-> mux_route.ret_channel == {active_control.channel_select_field[1:0],
    ~active_control.channel_select_field[2]})
    else $error("return route wrong");
  trail_zero_a: assert property (
    $fell(hold_capacitor_to_return) |=> !result_out[*3])
    else $error("trailing bits wrong");
endmodule // adc_serial_asserts

bind adc_serial_conversion_control adc_serial_asserts i_chk (
  .reset_n, .serial_clk, .chip_select_n, .result_out,
  .conversion_strobe_out, .dac_trial, .mux_route, .track_enable,
  .hold_capacitor_to_return, .active_control
);

// >>> adc_serial_conversion_control.sv
// Overview of operation
// - Single-ended: positive to channel, return to ground.
// - Differential: adjacent pair feeds positive and return.
// - Acquisition spans three clocks, ends after bit eight.
// - Track after fifth bit, hold after eighth.
// - Hold capacitor to return during conversion only.
// - All-ones byte: channel seven, single-ended, unipolar, external.
// - Strobe pulses one clock before result MSB.
// - A conversion cycle needs twenty-four serial clocks.
// - Strobe and data change on falling edges.
// - Capture one command bit per rising edge.
// - Skip leading zeros; first one starts byte.
// - Control byte field layout start, select, modes.
// - Polarity bit one unipolar, zero bipolar.
// - Result framed by one leading, three trailing zeros.
// - Chip select high: ignore input, float outputs.
`timescale 1ns/1ns
module adc_serial_conversion_control
  import adc_serial_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic serial_clk,
  input wire logic chip_select_n,
  input wire logic command_in,
  output logic result_out,
  output logic result_out_oe_n,
  output logic conversion_strobe_out,
  output logic conversion_strobe_oe_n,
  input wire logic comparator_high,
  output logic [11:0] dac_trial,
  output mux_type mux_route,
  output logic track_enable,
  output logic hold_capacitor_to_return,
  output control_type active_control,
  output logic result_valid,
  input wire logic result_ready,
  output result_type result_data
);

  // System clock domain: reset release and result hand-off.
  logic rst_meta;
  logic sys_rst_n;
  logic toggle_meta;
  logic toggle_sync;
  logic toggle_seen;
  logic next_toggle_seen;
  logic push_pending;
  logic next_push_pending;
  logic accept_level;
  logic next_accept_level;
  logic next_result_valid;
  result_type next_result_data;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [RESULT_WIDTH-1:0] fifo_out_data;

  // Link domain, rising edge: command receiver.
  logic link_rst;
  logic accept_meta;
  logic accept_sync;
  rx_state_type rx_state;
  rx_state_type next_rx_state;
  logic [3:0] rx_count;
  logic [3:0] next_rx_count;
  logic [7:0] rx_shift;
  logic [7:0] next_rx_shift;
  logic track_now;
  logic hold_now;
  logic [2:0] early_select;

  // Link domain, falling edge: track/hold and conversion sequencer.
  seq_state_type seq_state;
  seq_state_type next_seq_state;
  logic [3:0] seq_count;
  logic [3:0] next_seq_count;
  logic [3:0] bit_index;
  logic [11:0] next_dac_trial;
  logic next_result_out;
  logic next_strobe;
  logic next_track_enable;
  logic next_hold_to_return;
  mux_type next_mux_route;
  control_type next_active_control;
  control_type byte_fields;
  result_type result_word;
  result_type next_result_word;
  logic result_toggle;
  logic next_result_toggle;

  // The reset is released through two flip-flops before use.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta <= 1'b0;
      sys_rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      sys_rst_n <= rst_meta;
    end
  end

  // Chip select high clears the whole link front end at once, so
  // stray clocks while deselected can never start a byte.
  assign link_rst = chip_select_n || !sys_rst_n;

  // Route a select field onto the mux nodes.
  function automatic mux_type route_for(input logic [2:0] sel,
                                        input logic single);
    mux_type m;
    m.pos_channel = {sel[1], sel[0], sel[2]};
    m.ret_channel = {sel[1], sel[0], ~sel[2]};
    m.ret_ground = single;
    return m;
  endfunction

  // ---------------- Receiver on rising serial clock edges.

  always_comb begin
    next_rx_state = rx_state;
    next_rx_count = rx_count;
    next_rx_shift = rx_shift;
    unique case (rx_state)
      rx_hunt: begin
        next_rx_count = '0;
        if (command_in && accept_sync) begin
          next_rx_shift = {7'h00, command_in};
          next_rx_count = BIT_COUNT_START;
          next_rx_state = rx_byte;
        end
      end
      rx_byte: begin
        next_rx_shift = {rx_shift[6:0], command_in};
        next_rx_count = rx_count + 4'h1;
        if (next_rx_count == HOLD_AT_BIT) begin
          next_rx_state = rx_hunt;
        end
      end
    endcase
  end

  always_ff @(posedge serial_clk or posedge link_rst) begin
    if (link_rst) begin
      accept_meta <= 1'b0;
      accept_sync <= 1'b0;
      rx_state <= rx_hunt;
      rx_count <= '0;
      rx_shift <= '0;
    end else begin
      accept_meta <= accept_level;
      accept_sync <= accept_meta;
      rx_state <= next_rx_state;
      rx_count <= next_rx_count;
      rx_shift <= next_rx_shift;
    end
  end

  // Each count value from one to eight lasts exactly one rising-to-rising period, so the
  // falling edge in between sees it once.
  assign track_now = (rx_state == rx_byte) && (rx_count == TRACK_AT_BIT);
  assign hold_now = rx_count == HOLD_AT_BIT;
  assign early_select = rx_shift[3:1];
  assign byte_fields = {rx_shift[SEL_HI:SEL_LO], rx_shift[POL_POS],
                        rx_shift[CFG_POS], rx_shift[PD_HI:PD_LO]};
  assign bit_index = LAST_DECISION - seq_count;

  // ---------------- Sequencer on falling serial clock edges.

  always_comb begin
    next_seq_state = seq_state;
    next_seq_count = seq_count;
    next_dac_trial = dac_trial;
    next_result_out = 1'b0;
    next_strobe = 1'b0;
    next_track_enable = track_enable;
    next_hold_to_return = hold_capacitor_to_return;
    next_mux_route = mux_route;
    next_active_control = active_control;
    next_result_word = result_word;
    next_result_toggle = result_toggle;
    if (hold_now) begin
      // Acquisition closes three clocks after it opened.
      next_track_enable = 1'b0;
      next_hold_to_return = 1'b1;
      next_active_control = byte_fields;
      next_mux_route = route_for(byte_fields.channel_select_field,
                                 byte_fields.input_config_bit);
      next_strobe = byte_fields.power_clock_mode_field
                    == MODE_EXTERNAL;
      next_result_out = 1'b0;
      next_dac_trial = MSB_TRIAL;
      next_seq_count = '0;
      next_seq_state = seq_lead;
    end else begin
      if (track_now) begin
        // Channel select is known by now; return side follows at hold.
        next_track_enable = 1'b1;
        next_mux_route = route_for(early_select, mux_route.ret_ground);
      end
      unique case (seq_state)
        seq_idle: begin
          next_result_out = 1'b0;
        end
        seq_lead, seq_convert: begin
          next_dac_trial[bit_index] = comparator_high;
          if (bit_index != 4'h0) begin
            next_dac_trial[bit_index - 4'h1] = 1'b1;
          end
          next_result_out = comparator_high;
          next_seq_count = seq_count + 4'h1;
          next_seq_state = seq_convert;
          if (seq_count == LAST_DECISION) begin
            next_hold_to_return = 1'b0;
            next_result_word.code = next_dac_trial;
            next_result_word.pos_channel = mux_route.pos_channel;
            next_result_word.unipolar =
              active_control.polarity_mode_bit;
            next_result_word.single_ended =
              active_control.input_config_bit;
            next_result_toggle = !result_toggle;
            next_seq_count = '0;
            next_seq_state = seq_trail;
          end
        end
        seq_trail: begin
          next_result_out = 1'b0;
          next_seq_count = seq_count + 4'h1;
          if (next_seq_count == TRAIL_ZEROS) begin
            next_seq_state = seq_idle;
          end
        end
      endcase
    end
  end

  always_ff @(negedge serial_clk or posedge link_rst) begin
    if (link_rst) begin
      seq_state <= seq_idle;
      seq_count <= '0;
      dac_trial <= '0;
      result_out <= 1'b0;
      result_out_oe_n <= 1'b1;
      conversion_strobe_out <= 1'b0;
      conversion_strobe_oe_n <= 1'b1;
      track_enable <= 1'b0;
      hold_capacitor_to_return <= 1'b0;
      mux_route <= MUX_RESET;
      active_control <= CONTROL_RESET;
    end else begin
      seq_state <= next_seq_state;
      seq_count <= next_seq_count;
      dac_trial <= next_dac_trial;
      result_out <= next_result_out;
      result_out_oe_n <= 1'b0;
      conversion_strobe_out <= next_strobe;
      conversion_strobe_oe_n <= 1'b0;
      track_enable <= next_track_enable;
      hold_capacitor_to_return <= next_hold_to_return;
      mux_route <= next_mux_route;
      active_control <= next_active_control;
    end
  end

  // The finished word and its toggle survive chip select going high,
  // since the system side may still be picking them up.
  always_ff @(negedge serial_clk or negedge sys_rst_n) begin
    if (!sys_rst_n) begin
      result_word <= RESULT_RESET;
      result_toggle <= 1'b0;
    end else begin
      result_word <= next_result_word;
      result_toggle <= next_result_toggle;
    end
  end

  // ---------------- System side: result crossing and buffering.

  // The word is stable for at least eleven serial clocks after the
  // toggle moves, far longer than the two-stage synchroniser needs.
  always_comb begin
    next_toggle_seen = toggle_seen;
    next_push_pending = push_pending;
    if (push_pending && fifo_in_ready) begin
      next_push_pending = 1'b0;
    end
    if (toggle_sync != toggle_seen) begin
      next_toggle_seen = toggle_sync;
      next_push_pending = 1'b1;
    end
    // A full buffer refuses new start bits at the link instead of
    // dropping finished results.
    next_accept_level = fifo_in_ready && !next_push_pending;
    next_result_valid = result_valid;
    next_result_data = result_data;
    if (fifo_out_ready) begin
      next_result_valid = fifo_out_valid;
      next_result_data = result_type'(fifo_out_data);
    end
  end

  assign fifo_out_ready = !result_valid || result_ready;

  always_ff @(posedge clk or negedge sys_rst_n) begin
    if (!sys_rst_n) begin
      toggle_meta <= 1'b0;
      toggle_sync <= 1'b0;
      toggle_seen <= 1'b0;
      push_pending <= 1'b0;
      accept_level <= 1'b0;
      result_valid <= 1'b0;
      result_data <= RESULT_RESET;
    end else begin
      toggle_meta <= result_toggle;
      toggle_sync <= toggle_meta;
      toggle_seen <= next_toggle_seen;
      push_pending <= next_push_pending;
      accept_level <= next_accept_level;
      result_valid <= next_result_valid;
      result_data <= next_result_data;
    end
  end

  result_fifo #(
    .WIDTH(RESULT_WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) u_result_fifo (
    .clk(clk),
    .rst_n(sys_rst_n),
    .in_valid(push_pending),
    .in_ready(fifo_in_ready),
    .in_data(result_word),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );

endmodule // adc_serial_conversion_control

// >>> adc_serial_conversion_control_tb_top.sv
`timescale 1ns/1ns
`define CHECK(got, exp) begin \
  check_count++; \
  if ((got) !== (exp)) begin \
    bad_count++; \
    $display("ERROR %0t: got %h want %h", $time, got, exp); \
  end \
end
module adc_serial_conversion_control_tb_top
  import adc_serial_pkg::*;
;
  typedef struct packed {
    logic [7:0] ctrl;
    logic [11:0] code;
  } row_type;
  row_type rows [8] = '{
    '{8'hff, 12'h800}, '{8'h83, 12'h000}, '{8'h9f, 12'hfff},
    '{8'hc7, 12'h001}, '{8'hd3, 12'h7ff}, '{8'he8, 12'ha5c},
    '{8'hb5, 12'h3c3}, '{8'hfe, 12'h555}};
  logic clk, reset_n, serial_clk, chip_select_n, command_in;
  logic result_out, result_out_oe_n, conversion_strobe_out;
  logic conversion_strobe_oe_n, comparator_high, track_enable;
  logic hold_capacitor_to_return, result_valid, result_ready;
  logic [11:0] dac_trial, code;
  mux_type mux_route;
  control_type active_control;
  result_type result_data;
  int bad_count = 0;
  int check_count = 0;

  adc_serial_conversion_control i_dut (
    .clk, .reset_n, .serial_clk, .chip_select_n, .command_in,
    .result_out, .result_out_oe_n, .conversion_strobe_out,
    .conversion_strobe_oe_n, .comparator_high, .dac_trial, .mux_route,
    .track_enable, .hold_capacitor_to_return, .active_control,
    .result_valid, .result_ready, .result_data
  );

  adc_host_model i_host (
    .serial_clk, .chip_select_n, .command_in, .comparator_high,
    .result_out, .result_out_oe_n, .dac_trial, .analog_code(code)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic report_and_stop;
    $display("checks %0d errors %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Holding ready low until the check keeps the word from slipping past.
  task automatic take_word(input result_type exp);
    int n = 0;
    @(negedge clk);
    while (result_valid !== 1'b1) begin
      @(negedge clk);
      n++;
      if (n > 100) begin
        bad_count++;
        report_and_stop;
      end
    end
    `CHECK(result_data, exp)
    result_ready = 1'b1;
    @(negedge clk);
    result_ready = 1'b0;
  endtask

  initial begin
    #200000;
    bad_count++;
    report_and_stop;
  end

  initial begin
    logic [23:0] rx;
    reset_n = 1'b0;
    result_ready = 1'b0;
    code = 12'h000;
    repeat (6) @(negedge clk);
    `CHECK(result_out_oe_n, 1'b1)
    `CHECK(mux_route, MUX_RESET)
    `CHECK(result_valid, 1'b0)
    reset_n = 1'b1;
    repeat (3) @(negedge clk);
    foreach (rows[i]) begin
      code = rows[i].code;
      i_host.frame({rows[i].ctrl, 16'h0000}, rx);
      `CHECK(rx[15:0], {1'b0, rows[i].code, 3'h0})
      // Chip select clears the link side in the same step; let it settle.
      @(negedge clk);
      `CHECK(conversion_strobe_oe_n, 1'b1)
      `CHECK(result_out_oe_n, 1'b1)
      take_word({rows[i].code, rows[i].ctrl[5:4], rows[i].ctrl[6],
        rows[i].ctrl[3:2]});
    end
    // Fill the buffer with the reader stalled; late frames are refused.
    for (int i = 0; i < 36; i++) begin
      code = 12'(i * 97);
      i_host.frame(24'hff0000, rx);
    end
    for (int i = 0; i < 33; i++) begin
      take_word({12'(i * 97), 5'h1f});
    end
    repeat (20) @(negedge clk);
    `CHECK(result_valid, 1'b0)
    report_and_stop;
  end
endmodule // adc_serial_conversion_control_tb_top

// >>> adc_serial_pkg.sv
package adc_serial_pkg;

  // Control byte layout.
  localparam int CTRL_BITS = 8;
  localparam int SEL_HI = 6;
  localparam int SEL_LO = 4;
  localparam int POL_POS = 3;
  localparam int CFG_POS = 2;
  localparam int PD_HI = 1;
  localparam int PD_LO = 0;

  // Receive bit counts at byte start and where the track/hold stage changes.
  localparam logic [3:0] BIT_COUNT_START = 4'h1;
  localparam logic [3:0] TRACK_AT_BIT = 4'h5;
  localparam logic [3:0] HOLD_AT_BIT = 4'h8;

  // Result framing.
  localparam int RESULT_BITS = 12;
  localparam logic [3:0] LAST_DECISION = 4'hb;
  localparam logic [3:0] TRAIL_ZEROS = 4'h3;
  localparam logic [11:0] MSB_TRIAL = 12'h800;

  localparam int FIFO_DEPTH = 32;

  localparam logic [1:0] MODE_FULL_PD = 2'h0;
  localparam logic [1:0] MODE_FAST_PD = 2'h1;
  localparam logic [1:0] MODE_INTERNAL = 2'h2;
  localparam logic [1:0] MODE_EXTERNAL = 2'h3;

  typedef struct packed {
    logic [2:0] channel_select_field;
    logic polarity_mode_bit;
    logic input_config_bit;
    logic [1:0] power_clock_mode_field;
  } control_type;

  localparam control_type CONTROL_RESET = 7'h00;

  typedef struct packed {
    logic [2:0] pos_channel;
    logic [2:0] ret_channel;
    logic ret_ground;
  } mux_type;

  localparam mux_type MUX_RESET = 7'h01;

  typedef struct packed {
    logic [11:0] code;
    logic [2:0] pos_channel;
    logic unipolar;
    logic single_ended;
  } result_type;

  localparam int RESULT_WIDTH = $bits(result_type);
  localparam result_type RESULT_RESET = 17'h00000;

  typedef enum logic {
    rx_hunt = 1'b0,
    rx_byte = 1'b1
  } rx_state_type;

  typedef enum logic [1:0] {
    seq_idle = 2'b00,
    seq_lead = 2'b01,
    seq_convert = 2'b10,
    seq_trail = 2'b11
  } seq_state_type;

endpackage

// >>> result_fifo.sv
`timescale 1ns/1ns
module result_fifo #(
  parameter int WIDTH = 17,
  parameter int DEPTH = 32
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [PW:0] count;
  logic [PW-1:0] next_wr_ptr;
  logic [PW-1:0] next_rd_ptr;
  logic [PW:0] next_count;
  logic push;
  logic pop;

  assign in_ready = count != (PW+1)'(DEPTH);
  assign out_valid = count != '0;
  assign out_data = mem[rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_count = count;
    if (push) begin
      next_wr_ptr = (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
    end
    if (pop) begin
      next_rd_ptr = (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
    end
    if (push && !pop) begin
      next_count = count + 1'b1;
    end else if (pop && !push) begin
      next_count = count - 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
    end
  end

  // The storage needs no reset; out_valid is set only while rd_ptr points at a written word.
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end
endmodule // result_fifo
